// ### core/eee_mmd_regs.sv
// indirect eee and link status registers behind clause 22 regs 13/14
// assumes the management front end turns frames into read/write strobes
// How it works
// - host reaches the set only through window registers 13 and 14.
// - each location is a device address plus a register address.
// - time sync registers 1.1800 to 1.1807 read zero while link down.
// - pma link bit 2 is latching low, one means link up.
// - tx lpi seen bit 11 latches high until the register is read.
// - rx lpi seen bit 10 latches high until the register is read.
// - bit 9 shows live tx lpi state at read time.
// - bit 8 shows live rx lpi state at read time.
// - pcs link bit 2 is latching low, one means link up.
// - capability register reads one in bit 1, rest reserved zero.
// - each wake fault bumps the wake error counter, which holds at all ones.
// - sixteen bit counter clears on read and on hard or soft reset.
// - local advert bit 1 read write, resets zero, feeds the next page.
// - partner advert register is read only, writes ignored.
// - on autoneg done, partner advert bit 1 loads partner capability.
`timescale 1ns/1ps
module eee_mmd_regs
  import eee_mmd_pkg::*;
#(
  parameter logic [15:0] TS_CAP_VAL = 16'h0000,
  parameter logic [15:0] TX_MAX_VAL = 16'h0000,
  parameter logic [15:0] TX_MIN_VAL = 16'h0000,
  parameter logic [15:0] RX_MAX_VAL = 16'h0000,
  parameter logic [15:0] RX_MIN_VAL = 16'h0000
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // clause 22 register window
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // pma, pcs and autoneg status
  input wire logic pma_link_i,
  input wire logic pcs_link_i,
  input wire logic tx_lpi_i,
  input wire logic rx_lpi_i,
  input wire logic wake_fault_i,
  input wire logic an_done_i,
  input wire logic partner_eee_tx_i,
  input wire logic sw_reset_i,
  // to autoneg next page
  output logic advert_eee_tx_o
);
  import eee_mmd_pkg::*;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // window state
  mmd_fn_t mmd_fn;
  logic [4:0] mmd_dev;
  logic [15:0] mmd_addr;
  logic lp_adv;
  logic [15:0] next_rdata;

  // access strobes
  logic data_acc;
  logic mmd_rd;
  logic mmd_wr;
  logic rd_pma;
  logic rd_pcs;
  logic rd_cnt;
  logic post_inc;
  logic in_ts;

  // latches and counter
  flag_if #(.W(1)) pma_drop ();
  flag_if #(.W(1)) pcs_drop ();
  flag_if #(.W(1)) tx_seen ();
  flag_if #(.W(1)) rx_seen ();
  flag_if #(.W(CNT_W)) wake_cnt ();

  // true when the window points at device dev, register adr
  function automatic logic hit(input logic [4:0] dev,
                               input logic [15:0] adr);
    hit = (mmd_dev == dev) && (mmd_addr == adr);
  endfunction : hit

  // pma status word with latching low link
  function automatic logic [15:0] pma_word(input logic link,
                                           input logic drop);
    pma_word = '0;
    pma_word[LINK_BIT] = link && !drop;
  endfunction : pma_word

  // decode of window accesses
  assign data_acc = (reg_addr_i == DATA_REG) && (mmd_fn != FN_ADDR);
  assign mmd_rd = reg_rd_i && data_acc;
  assign mmd_wr = reg_wr_i && data_acc;
  assign rd_pma = mmd_rd && hit(DEV_PMA, PMA_STAT1);
  assign rd_pcs = mmd_rd && hit(DEV_PCS, PCS_STAT1);
  assign rd_cnt = mmd_rd && hit(DEV_PCS, WAKE_CNT);
  assign in_ts = (mmd_dev == DEV_PMA) && (mmd_addr >= TS_CAP) &&
                 (mmd_addr <= TS_TOP);

  // address steps after data reads and writes in FN_INC_RW, after data writes only in FN_INC_WR
  always_comb begin
    post_inc = 1'b0;
    unique case (mmd_fn)
      FN_ADDR: post_inc = 1'b0;
      FN_DATA: post_inc = 1'b0;
      FN_INC_RW: post_inc = mmd_rd || mmd_wr;
      FN_INC_WR: post_inc = mmd_wr;
    endcase
  end

  // line events into the sticky flags
  assign pma_drop.event_hit = !pma_link_i;
  assign pma_drop.rd_clear = rd_pma || sw_reset_i;
  assign pcs_drop.event_hit = !pcs_link_i;
  assign pcs_drop.rd_clear = rd_pcs || sw_reset_i;
  assign tx_seen.event_hit = tx_lpi_i;
  assign tx_seen.rd_clear = rd_pcs || sw_reset_i;
  assign rx_seen.event_hit = rx_lpi_i;
  assign rx_seen.rd_clear = rd_pcs || sw_reset_i;
  assign wake_cnt.event_hit = wake_fault_i;
  assign wake_cnt.rd_clear = rd_cnt || sw_reset_i;

  sticky_flag u_pma_drop (
    .clock_i (clock_i),
    .rst_i (rst_i),
    .fl (pma_drop)
  );
  sticky_flag u_pcs_drop (
    .clock_i (clock_i),
    .rst_i (rst_i),
    .fl (pcs_drop)
  );
  sticky_flag u_tx_seen (
    .clock_i (clock_i),
    .rst_i (rst_i),
    .fl (tx_seen)
  );
  sticky_flag u_rx_seen (
    .clock_i (clock_i),
    .rst_i (rst_i),
    .fl (rx_seen)
  );
  fault_counter #(.W(CNT_W)) u_wake_cnt (
    .clock_i (clock_i),
    .rst_i (rst_i),
    .fl (wake_cnt)
  );

  // control register: function and device
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mmd_fn <= mmd_fn_t'(CTRL_RST[FN_MSB:FN_LSB]);
      mmd_dev <= CTRL_RST[4:0];
    end else if (reg_wr_i && reg_addr_i == CTRL_REG) begin
      mmd_fn <= mmd_fn_t'(reg_wdata_i[FN_MSB:FN_LSB]);
      mmd_dev <= reg_wdata_i[4:0];
    end
  end

  // address register: loaded in address mode, stepped in increment modes
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mmd_addr <= ADDR_RST;
    end else if (reg_wr_i && reg_addr_i == DATA_REG &&
                 mmd_fn == FN_ADDR) begin
      mmd_addr <= reg_wdata_i;
    end else if (post_inc) begin
      mmd_addr <= mmd_addr + 16'h0001;
    end
  end

  // local advertisement, the only writable bit in the set
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      advert_eee_tx_o <= ADV_RST;
    end else if (mmd_wr && hit(DEV_AN, LOC_ADV)) begin
      advert_eee_tx_o <= reg_wdata_i[EEE_TX_BIT];
    end
  end

  // partner advertisement, loaded only by autoneg completion
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      lp_adv <= LP_RST;
    end else if (an_done_i) begin
      lp_adv <= partner_eee_tx_i;
    end
  end

  // read data selection
  always_comb begin
    next_rdata = '0;
    if (reg_addr_i == CTRL_REG) begin
      next_rdata[FN_MSB:FN_LSB] = mmd_fn;
      next_rdata[4:0] = mmd_dev;
    end else if (reg_addr_i == DATA_REG && mmd_fn == FN_ADDR) begin
      next_rdata = mmd_addr;
    end else if (data_acc) begin
      if (in_ts && !pma_link_i) begin
        next_rdata = '0;
      end else if (hit(DEV_PMA, PMA_STAT1)) begin
        next_rdata = pma_word(pma_link_i, pma_drop.value);
      end else if (hit(DEV_PMA, TS_CAP)) begin
        next_rdata = TS_CAP_VAL;
      end else if (hit(DEV_PMA, TX_MAX)) begin
        next_rdata = TX_MAX_VAL;
      end else if (hit(DEV_PMA, TX_MIN)) begin
        next_rdata = TX_MIN_VAL;
      end else if (hit(DEV_PMA, RX_MAX)) begin
        next_rdata = RX_MAX_VAL;
      end else if (hit(DEV_PMA, RX_MIN)) begin
        next_rdata = RX_MIN_VAL;
      end else if (hit(DEV_PCS, PCS_STAT1)) begin
        next_rdata[TX_SEEN_BIT] = tx_seen.value;
        next_rdata[RX_SEEN_BIT] = rx_seen.value;
        next_rdata[TX_NOW_BIT] = tx_lpi_i;
        next_rdata[RX_NOW_BIT] = rx_lpi_i;
        next_rdata[LINK_BIT] = pcs_link_i && !pcs_drop.value;
      end else if (hit(DEV_PCS, EEE_ABIL)) begin
        next_rdata = ABIL_VAL;
      end else if (hit(DEV_PCS, WAKE_CNT)) begin
        next_rdata = wake_cnt.value;
      end else if (hit(DEV_AN, LOC_ADV)) begin
        next_rdata[EEE_TX_BIT] = advert_eee_tx_o;
      end else if (hit(DEV_AN, LP_ADV)) begin
        next_rdata[EEE_TX_BIT] = lp_adv;
      end
    end
  end

  // read answer, one cycle after the strobe
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // checks on the read path, the status bits, the advert registers and address stepping
  chk_ts_zero_down: assert property (
    (mmd_rd && in_ts && !pma_link_i) |=> reg_rvalid_o && reg_rdata_o == '0)
    else $error("time sync read nonzero with link down");

  chk_pma_ll_first: assert property (
    (rd_pma && pma_drop.value) |=> reg_rdata_o[LINK_BIT] == 1'b0)
    else $error("pma link drop not reported");

  chk_ll_recover: assert property (
    (rd_pma && pma_link_i && !sw_reset_i) |=> !pma_drop.value)
    else $error("pma link latch not released by read");

  chk_pcs_ll_bit: assert property (
    (!pcs_link_i && !rd_pcs) ##1 rd_pcs |=> reg_rdata_o[LINK_BIT] == 1'b0)
    else $error("pcs link drop not reported");

  chk_lpi_seen: assert property (
    (tx_lpi_i ##1 rd_pcs) |=> reg_rdata_o[TX_SEEN_BIT])
    else $error("tx lpi seen bit lost");

  chk_lpi_live: assert property (
    rd_pcs |=> reg_rdata_o[TX_NOW_BIT] == $past(tx_lpi_i) &&
               reg_rdata_o[RX_NOW_BIT] == $past(rx_lpi_i))
    else $error("live lpi bits wrong");

  chk_abil_value: assert property (
    (mmd_rd && hit(DEV_PCS, EEE_ABIL)) |=> reg_rdata_o == ABIL_VAL)
    else $error("capability register wrong");

  chk_adv_write: assert property (
    (mmd_wr && hit(DEV_AN, LOC_ADV)) |=>
      advert_eee_tx_o == $past(reg_wdata_i[EEE_TX_BIT]))
    else $error("local advert write not taken");

  chk_lp_no_write: assert property (
    (mmd_wr && hit(DEV_AN, LP_ADV) && !an_done_i) |=> $stable(lp_adv))
    else $error("partner advert changed by write");

  chk_lp_load: assert property (
    an_done_i |=> lp_adv == $past(partner_eee_tx_i))
    else $error("partner advert not loaded");

  chk_window_only: assert property (
    (reg_rd_i && reg_addr_i != CTRL_REG && reg_addr_i != DATA_REG) |=>
      reg_rdata_o == '0)
    else $error("read outside window returned data");

  chk_inc_step: assert property (
    (mmd_wr && mmd_fn == FN_INC_WR) |=> mmd_addr == $past(mmd_addr) + 16'h0001)
    else $error("address did not step");

  // checks on window decode, address stepping, the counter read, live and seen status bits and advert holds
  chk_rvalid_pulse: assert property (
    reg_rvalid_o == $past(reg_rd_i))
    else $error("read valid not one cycle after strobe");

  chk_ctrl_readback: assert property (
    (reg_rd_i && reg_addr_i == CTRL_REG) |=>
      reg_rdata_o == {$past(mmd_fn), 9'h000, $past(mmd_dev)})
    else $error("control register readback wrong");

  chk_inc_rw_step: assert property (
    (mmd_rd && mmd_fn == FN_INC_RW) |=> mmd_addr == $past(mmd_addr) + 16'h0001)
    else $error("address did not step on read");

  chk_data_no_step: assert property (
    (data_acc && mmd_fn == FN_DATA) |=> $stable(mmd_addr))
    else $error("address moved in plain data mode");

  chk_pma_live_bit: assert property (
    (rd_pma && !pma_drop.value) |=> reg_rdata_o[LINK_BIT] == $past(pma_link_i))
    else $error("pma link bit not live");

  chk_pcs_live_bit: assert property (
    (rd_pcs && !pcs_drop.value) |=> reg_rdata_o[LINK_BIT] == $past(pcs_link_i))
    else $error("pcs link bit not live");

  chk_rx_seen: assert property (
    (rx_lpi_i ##1 rd_pcs) |=> reg_rdata_o[RX_SEEN_BIT])
    else $error("rx lpi seen bit lost");

  chk_cnt_read: assert property (
    rd_cnt |=> reg_rdata_o == $past(wake_cnt.value))
    else $error("counter read lost its value");

  chk_cnt_zero: assert property (
    (rd_cnt && !wake_fault_i) |=> wake_cnt.value == '0)
    else $error("counter not cleared by its read");

  chk_adv_hold: assert property (
    !(mmd_wr && hit(DEV_AN, LOC_ADV)) |=> $stable(advert_eee_tx_o))
    else $error("local advert changed without a write");

  chk_lp_hold: assert property (
    !an_done_i |=> $stable(lp_adv))
    else $error("partner advert changed without autoneg");
endmodule : eee_mmd_regs

// ### shared/eee_mmd_pkg.sv
// constants for the indirect eee / link status register set
// assumes clause 22 registers 13 and 14 form the only access window
package eee_mmd_pkg;
  // clause 22 window registers
  localparam logic [4:0] CTRL_REG = 5'h0D;
  localparam logic [4:0] DATA_REG = 5'h0E;
  // access function field of the control register
  localparam int FN_MSB = 15;
  localparam int FN_LSB = 14;
  typedef enum logic [1:0] {
    FN_ADDR = 2'b00,
    FN_DATA = 2'b01,
    FN_INC_RW = 2'b10,
    FN_INC_WR = 2'b11
  } mmd_fn_t;
  // device addresses
  localparam logic [4:0] DEV_PMA = 5'h01;
  localparam logic [4:0] DEV_PCS = 5'h03;
  localparam logic [4:0] DEV_AN = 5'h07;
  // register addresses inside a device
  localparam logic [15:0] PMA_STAT1 = 16'h0001;
  localparam logic [15:0] TS_CAP = 16'h0708;
  localparam logic [15:0] TX_MAX = 16'h0709;
  localparam logic [15:0] TX_MIN = 16'h070B;
  localparam logic [15:0] RX_MAX = 16'h070D;
  localparam logic [15:0] RX_MIN = 16'h070F;
  localparam logic [15:0] TS_TOP = 16'h070F;
  localparam logic [15:0] PCS_STAT1 = 16'h0001;
  localparam logic [15:0] EEE_ABIL = 16'h0014;
  localparam logic [15:0] WAKE_CNT = 16'h0016;
  localparam logic [15:0] LOC_ADV = 16'h003C;
  localparam logic [15:0] LP_ADV = 16'h003D;
  // field positions
  localparam int LINK_BIT = 2;
  localparam int TX_SEEN_BIT = 11;
  localparam int RX_SEEN_BIT = 10;
  localparam int TX_NOW_BIT = 9;
  localparam int RX_NOW_BIT = 8;
  localparam int EEE_TX_BIT = 1;
  // reset and fixed values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic ADV_RST = 1'b0;
  localparam logic LP_RST = 1'b0;
  localparam logic [15:0] ABIL_VAL = 16'h0002;
  localparam int CNT_W = 16;
endpackage : eee_mmd_pkg

// ### shared/flag_if.sv
// carrier between the register core and its sticky flags / counter
// assumes one instance per flag or counter
`timescale 1ns/1ps
interface flag_if #(parameter int W = 1);
  logic event_hit;
  logic rd_clear;
  logic [W-1:0] value;
  modport owner (input event_hit, input rd_clear, output value);
  modport user (output event_hit, output rd_clear, input value);
endinterface : flag_if

// ### core/sticky_flag.sv
// one sticky flag: set by a line event, cleared by a register read
// assumes clear strobe already includes software reset
`timescale 1ns/1ps
module sticky_flag (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // event and clear
  flag_if.owner fl
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // set wins over a read in the same cycle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fl.value <= 1'b0;
    end else if (fl.event_hit) begin
      fl.value <= 1'b1;
    end else if (fl.rd_clear) begin
      fl.value <= 1'b0;
    end
  end

  chk_set_beats_clear: assert property (
    fl.event_hit |=> fl.value ##1 (fl.value || $past(fl.rd_clear)))
    else $error("sticky flag lost an event");
endmodule : sticky_flag

// ### core/fault_counter.sv
// wake fault counter, cleared by read or reset, saturates at all ones
// assumes clear strobe already includes software reset
`timescale 1ns/1ps
module fault_counter #(parameter int W = 16) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // count and clear
  flag_if.owner fl
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // a fault in the clearing cycle is kept as a count of one
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fl.value <= '0;
    end else if (fl.rd_clear) begin
      fl.value <= {{(W-1){1'b0}}, fl.event_hit};
    end else if (fl.event_hit && !(&fl.value)) begin
      fl.value <= fl.value + 1'b1;
    end
  end

  chk_count_step: assert property (
    (fl.event_hit && !fl.rd_clear && !(&fl.value)) |=>
      fl.value == $past(fl.value) + 1'b1)
    else $error("wake fault not counted");
  chk_count_clear: assert property (
    (fl.rd_clear && !fl.event_hit) |=> fl.value == '0 ##1 fl.value <= 1)
    else $error("counter not cleared by read");
endmodule : fault_counter

// ### verification/mgmt_host_model.sv
// station management host model: indirect access through registers 13 and 14
// assumes one clock shared with the register core, strobes one cycle long
`timescale 1ns/1ps
module mgmt_host_model (
  // clock
  input wire logic clock_i,
  // clause 22 window, host side
  output logic [4:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [15:0] reg_wdata_o,
  input wire logic [15:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  import eee_mmd_pkg::*;
  // idle window lines at time zero
  initial begin
    reg_addr_o = 5'h1F;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 16'h0000;
  end
  // one window access; idle lines show the inverse after release
  task cyc(input logic [4:0] a, input logic wr, input logic [15:0] d,
           output logic [15:0] q);
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_wr_o <= wr;
    reg_rd_o <= !wr;
    reg_wdata_o <= d;
    @(posedge clock_i);
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
    // answer taken at the edge that samples read valid high
    @(posedge clock_i);
    q = (!wr && reg_rvalid_i === 1'b1) ? reg_rdata_i : 16'hXXXX;
  endtask : cyc
  // select device and register, then switch the window to data
  task sel(input logic [4:0] dev, input logic [15:0] adr);
    logic [15:0] q;
    cyc(CTRL_REG, 1'b1, {FN_ADDR, 9'h000, dev}, q);
    cyc(DATA_REG, 1'b1, adr, q);
    cyc(CTRL_REG, 1'b1, {FN_DATA, 9'h000, dev}, q);
  endtask : sel
  // indirect read of one location
  task mmd_rd(input logic [4:0] dev, input logic [15:0] adr, output logic [15:0] q);
    sel(dev, adr);
    cyc(DATA_REG, 1'b0, 16'h0000, q);
  endtask : mmd_rd
  // indirect write of one location
  task mmd_wr(input logic [4:0] dev, input logic [15:0] adr, input logic [15:0] d);
    logic [15:0] q;
    sel(dev, adr);
    cyc(DATA_REG, 1'b1, d, q);
  endtask : mmd_wr
endmodule : mgmt_host_model

// ### verification/tb_top.sv
// self-checking bench for the indirect eee and link status registers
// assumes the host model drives the window and the bench drives line status
`timescale 1ns/1ps
module tb_top;
  import eee_mmd_pkg::*;
  localparam logic [15:0] CAP_V = 16'h0001;
  localparam logic [15:0] TXMAX_V = 16'h00A5;
  localparam int LIMIT = 4000;
  typedef struct {logic [4:0] dev; logic [15:0] adr; logic pma; logic [15:0] exp;} row_t;
  // ordinary cases: location, pma link level, expected read value
  row_t rows [0:7] = '{
    '{DEV_PCS, EEE_ABIL, 1'b0, ABIL_VAL},
    '{DEV_PMA, TS_CAP, 1'b0, 16'h0000},
    '{DEV_PMA, TS_CAP, 1'b1, CAP_V},
    '{DEV_PMA, TX_MAX, 1'b0, 16'h0000},
    '{DEV_PMA, TX_MAX, 1'b1, TXMAX_V},
    '{DEV_AN, LOC_ADV, 1'b1, 16'h0000},
    '{DEV_AN, LP_ADV, 1'b1, 16'h0000},
    '{DEV_PCS, 16'h0063, 1'b1, 16'h0000}};
  logic clock_i, rst_i;
  logic [4:0] reg_addr;
  logic reg_wr, reg_rd, reg_rvalid, advert;
  logic [15:0] reg_wdata, reg_rdata, q;
  logic pma, pcs, txl, rxl, fault, an_done, partner, sw_rst;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  // clock at 200 MHz
  initial clock_i = 1'b0;
  always #2.5 clock_i = ~clock_i;
  eee_mmd_regs #(.TS_CAP_VAL(CAP_V), .TX_MAX_VAL(TXMAX_V)) u_eee_mmd_regs (
    .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .reg_rvalid_o(reg_rvalid), .pma_link_i(pma), .pcs_link_i(pcs), .tx_lpi_i(txl),
    .rx_lpi_i(rxl), .wake_fault_i(fault), .an_done_i(an_done),
    .partner_eee_tx_i(partner), .sw_reset_i(sw_rst), .advert_eee_tx_o(advert));
  mgmt_host_model u_mgmt_host_model (
    .clock_i(clock_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid));
  // verdict and end of run
  task conclude;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // one comparison
  task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk
  // indirect read and compare
  task rdc(input string what, input logic [4:0] dev, input logic [15:0] adr,
           input logic [15:0] exp);
    u_mgmt_host_model.mmd_rd(dev, adr, q);
    chk(what, q, exp);
  endtask : rdc
  // hang guard
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      conclude();
    end
  end
  // main sequence
  initial begin
    rst_i = 1'b1;
    {pma, pcs, txl, rxl, fault, an_done, partner, sw_rst} = 8'h00;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clock_i);
      pma <= rows[i].pma;
      rdc($sformatf("row %0d", i), rows[i].dev, rows[i].adr, rows[i].exp);
    end
    // pma latching low link
    u_mgmt_host_model.mmd_rd(DEV_PMA, PMA_STAT1, q);
    rdc("pma up", DEV_PMA, PMA_STAT1, 16'h0004);
    @(posedge clock_i);
    pma <= 1'b0;
    repeat (2) @(posedge clock_i);
    pma <= 1'b1;
    rdc("pma drop held", DEV_PMA, PMA_STAT1, 16'h0000);
    rdc("pma after drop", DEV_PMA, PMA_STAT1, 16'h0004);
    // pcs link and lpi flags
    @(posedge clock_i);
    pcs <= 1'b1;
    u_mgmt_host_model.mmd_rd(DEV_PCS, PCS_STAT1, q);
    rdc("pcs up", DEV_PCS, PCS_STAT1, 16'h0004);
    @(posedge clock_i);
    txl <= 1'b1;
    repeat (2) @(posedge clock_i);
    txl <= 1'b0;
    rdc("tx lpi seen", DEV_PCS, PCS_STAT1, 16'h0804);
    rdc("tx lpi cleared", DEV_PCS, PCS_STAT1, 16'h0004);
    @(posedge clock_i);
    rxl <= 1'b1;
    rdc("rx lpi live", DEV_PCS, PCS_STAT1, 16'h0504);
    @(posedge clock_i);
    rxl <= 1'b0;
    txl <= 1'b1;
    rdc("tx lpi live", DEV_PCS, PCS_STAT1, 16'h0E04);
    @(posedge clock_i);
    txl <= 1'b0;
    pcs <= 1'b0;
    repeat (2) @(posedge clock_i);
    pcs <= 1'b1;
    rdc("pcs drop held", DEV_PCS, PCS_STAT1, 16'h0800);
    rdc("pcs after drop", DEV_PCS, PCS_STAT1, 16'h0004);
    // read while the pcs link is still down
    @(posedge clock_i);
    pcs <= 1'b0;
    rdc("pcs down", DEV_PCS, PCS_STAT1, 16'h0000);
    @(posedge clock_i);
    pcs <= 1'b1;
    // wake fault counter
    for (int k = 0; k < 3; k++) begin
      @(posedge clock_i);
      fault <= 1'b1;
      @(posedge clock_i);
      fault <= 1'b0;
    end
    rdc("wake count", DEV_PCS, WAKE_CNT, 16'h0003);
    rdc("wake clear on read", DEV_PCS, WAKE_CNT, 16'h0000);
    @(posedge clock_i);
    fault <= 1'b1;
    @(posedge clock_i);
    fault <= 1'b0;
    sw_rst <= 1'b1;
    @(posedge clock_i);
    sw_rst <= 1'b0;
    rdc("wake soft reset", DEV_PCS, WAKE_CNT, 16'h0000);
    // local advertisement and hard reset
    u_mgmt_host_model.mmd_wr(DEV_AN, LOC_ADV, 16'hFFFF);
    rdc("local advert", DEV_AN, LOC_ADV, 16'h0002);
    chk("advert out", {15'h0000, advert}, 16'h0001);
    // a fault just before the hard reset must not survive it
    @(posedge clock_i);
    fault <= 1'b1;
    @(posedge clock_i);
    fault <= 1'b0;
    rst_i <= 1'b1;
    @(posedge clock_i);
    rst_i <= 1'b0;
    rdc("advert reset", DEV_AN, LOC_ADV, 16'h0000);
    chk("advert out reset", {15'h0000, advert}, 16'h0000);
    rdc("wake hard reset", DEV_PCS, WAKE_CNT, 16'h0000);
    // partner advertisement
    @(posedge clock_i);
    partner <= 1'b1;
    an_done <= 1'b1;
    @(posedge clock_i);
    an_done <= 1'b0;
    rdc("partner advert", DEV_AN, LP_ADV, 16'h0002);
    u_mgmt_host_model.mmd_wr(DEV_AN, LP_ADV, 16'h0000);
    rdc("partner write", DEV_AN, LP_ADV, 16'h0002);
    @(posedge clock_i);
    partner <= 1'b0;
    an_done <= 1'b1;
    @(posedge clock_i);
    an_done <= 1'b0;
    rdc("partner cleared", DEV_AN, LP_ADV, 16'h0000);
    // window registers themselves
    u_mgmt_host_model.cyc(5'h05, 1'b1, 16'hFFFF, q);
    u_mgmt_host_model.cyc(5'h05, 1'b0, 16'h0000, q);
    chk("other register", q, 16'h0000);
    u_mgmt_host_model.cyc(CTRL_REG, 1'b0, 16'h0000, q);
    chk("control readback", q, 16'h4007);
    // increment on read and write: two time sync words in a row
    u_mgmt_host_model.cyc(CTRL_REG, 1'b1, {FN_ADDR, 9'h000, DEV_PMA}, q);
    u_mgmt_host_model.cyc(DATA_REG, 1'b1, TS_CAP, q);
    u_mgmt_host_model.cyc(CTRL_REG, 1'b1, {FN_INC_RW, 9'h000, DEV_PMA}, q);
    u_mgmt_host_model.cyc(DATA_REG, 1'b0, 16'h0000, q);
    chk("inc read first", q, CAP_V);
    u_mgmt_host_model.cyc(DATA_REG, 1'b0, 16'h0000, q);
    chk("inc read second", q, TXMAX_V);
    // increment on write only: the write steps, the read does not
    u_mgmt_host_model.cyc(CTRL_REG, 1'b1, {FN_ADDR, 9'h000, DEV_AN}, q);
    u_mgmt_host_model.cyc(DATA_REG, 1'b1, LOC_ADV, q);
    u_mgmt_host_model.cyc(CTRL_REG, 1'b1, {FN_INC_WR, 9'h000, DEV_AN}, q);
    u_mgmt_host_model.cyc(DATA_REG, 1'b1, 16'h0002, q);
    u_mgmt_host_model.cyc(DATA_REG, 1'b0, 16'h0000, q);
    chk("inc write steps", q, 16'h0000);
    chk("advert by inc", {15'h0000, advert}, 16'h0001);
    u_mgmt_host_model.cyc(CTRL_REG, 1'b1, {FN_ADDR, 9'h000, DEV_AN}, q);
    u_mgmt_host_model.cyc(DATA_REG, 1'b0, 16'h0000, q);
    chk("address after inc", q, LP_ADV);
    conclude();
  end
endmodule : tb_top
